// file: common/alm_consts.vh
// Behaviour
// R1 - four channels: upper, lower, hysteresis, 12-bit values
// R2 - reset: upper full-scale, lower zero-scale
// R3 - result above upper sets flag, alert
// R4 - clear once hysteresis below upper limit
// R5 - result below lower sets flag, alert
// R6 - clear once hysteresis above lower limit
// R7 - hysteresis from the channel's own register
// R8 - config D2/D1 both one deasserts alert
// R9 - reads: bit15 flag, 14-12 zero, value
// R10 - hysteresis resets to 8 or 2
// R11 - host writes zero low bits, 10-bit
// R12 - all-ones hysteresis: capture min and max
// R13 - capture mode flag still reports, clears
// R14 - 8-bit status, high/low bit per channel
// R15 - later violations add bits, keep earlier
// R16 - config D2/D1 ones clears whole status
// R17 - all-ones status write clears everything
// R18 - write one clears that bit only
// R19 - status bit holds until host clears
// R20 - signal to pin, flag, or both (code: flag always signals; pin too only when D2=1, D1=0, never pin alone)
// R21 - pin alerts only for D2=1, D1=0
// R22 - after clear, config reads D2=1 D1=0
// R23 - polarity bit: 0 low, 1 high
// R24 - evaluate once per conversion, its channel
`ifndef ALM_CONSTS_VH
`define ALM_CONSTS_VH
// ----------------------------------------------------------------
// register pointer codes
// ----------------------------------------------------------------
`define ALM_PTR_RESULT   4'h0
`define ALM_PTR_STATUS   4'h1
`define ALM_PTR_CONFIG   4'h2
`define ALM_PTR_CYCLE    4'h3
`define ALM_PTR_LIM_BASE 4'h4
// ----------------------------------------------------------------
// configuration fields and reset values
// ----------------------------------------------------------------
`define ALM_CFG_POL      0
`define ALM_CFG_MODE     1
`define ALM_CFG_EN       2
`define ALM_CFG_RESET    8'h08
`define ALM_FLAG_BIT     15
`define ALM_FULL_SCALE   12'hFFF
`define ALM_ZERO_SCALE   12'h000
`define ALM_HYST_12BIT   12'h008
`define ALM_HYST_10BIT   12'h002
`define ALM_STAT_ALL     8'hFF
`endif

// file: rtl/alm_monitor.v
`timescale 1ns/10ps
`include "alm_consts.vh"
module alm_monitor #(
  parameter TEN_BIT = 0                  // 1 selects the 10-bit variant
) (
  input  wire        clock_i,            // 250 MHz device clock
  input  wire        reset_n_i,          // async reset, active low
  input  wire        wr_i,               // register write strobe
  input  wire [3:0]  ptr_i,              // register pointer
  input  wire [15:0] wdata_i,            // write data
  output reg  [15:0] rdata_o,            // registered read data
  input  wire        conv_done_i,        // one-cycle conversion done
  input  wire [1:0]  conv_chan_i,        // channel just converted
  input  wire [11:0] conv_result_i,      // conversion result
  output reg         alert_o,            // alert pin level
  output reg         alert_flag_o,       // result violation flag
  output wire [7:0]  config_o            // configuration readback
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [11:0] upper [0:3];
  reg [11:0] lower [0:3];
  reg [11:0] hyst  [0:3];
  reg [3:0]  in_alert;                   // per-channel active violation
  reg [7:0]  status;
  reg [7:0]  cfg;
  reg [7:0]  cycle;
  reg [15:0] last_result;
  integer    i;

  // reset hysteresis follows the variant, so compare and readback agree
  localparam [11:0] HYST_RST = TEN_BIT ? `ALM_HYST_10BIT
                                       : `ALM_HYST_12BIT; // R10

  // limit register decode: 4+3*ch+kind, kind 0 low,1 high,2 hyst
  function [3:0] lim_ptr;
    input [1:0] ch;
    input [1:0] kind;
    lim_ptr = `ALM_PTR_LIM_BASE + {ch, 1'b0} + {2'b00, ch} + {2'b00, kind};
  endfunction

  // ----------------------------------------------------------------
  // comparison of the converted channel
  // ----------------------------------------------------------------
  wire [11:0] c_up   = upper[conv_chan_i];
  wire [11:0] c_lo   = lower[conv_chan_i];
  wire [11:0] c_hy   = hyst[conv_chan_i];      // R7
  wire        capture = (c_hy == `ALM_FULL_SCALE);  // R12
  wire        over   = conv_result_i > c_up;   // R3
  wire        under  = conv_result_i < c_lo;   // R5
  // 13-bit sums keep the hysteresis edge from wrapping
  wire [12:0] up_gap = {1'b0, conv_result_i} + {1'b0, c_hy};
  wire [12:0] lo_gap = {1'b0, c_lo} + {1'b0, c_hy};
  wire        recov  = (up_gap <= {1'b0, c_up}) &&   // R4
                       ({1'b0, conv_result_i} >= lo_gap); // R6
  wire        cfg_wr = wr_i && (ptr_i == `ALM_PTR_CONFIG);
  wire        clr_all = cfg_wr && wdata_i[`ALM_CFG_EN]
                        && wdata_i[`ALM_CFG_MODE]; // R8 R16
  wire        pin_mode = cfg[`ALM_CFG_EN] && !cfg[`ALM_CFG_MODE]; // R21
  wire        any_alert = |in_alert;

  assign config_o = cfg;

  // ----------------------------------------------------------------
  // registers, monitor and status
  // ----------------------------------------------------------------
  // a result event beats a same-cycle host write to the same cell
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (i = 0; i < 4; i = i + 1) begin
        upper[i] <= `ALM_FULL_SCALE;       // R2
        lower[i] <= `ALM_ZERO_SCALE;       // R2
        hyst[i]  <= HYST_RST;              // R10
      end
      in_alert    <= 4'h0;
      status      <= 8'h00;
      cfg         <= `ALM_CFG_RESET;
      cycle       <= 8'h00;
      last_result <= 16'h0000;
    end else begin
      // host writes
      if (wr_i) begin
        if (ptr_i == `ALM_PTR_CONFIG) begin
          cfg <= wdata_i[7:0];
          if (clr_all)
            cfg[`ALM_CFG_MODE] <= 1'b0;    // R22
        end
        if (ptr_i == `ALM_PTR_CYCLE)
          cycle <= wdata_i[7:0];
        for (i = 0; i < 4; i = i + 1) begin
          // R11: low bits stored as written; host keeps them zero
          if (ptr_i == lim_ptr(i[1:0], 2'd0))
            lower[i] <= wdata_i[11:0];     // R1
          if (ptr_i == lim_ptr(i[1:0], 2'd1))
            upper[i] <= wdata_i[11:0];     // R1
          if (ptr_i == lim_ptr(i[1:0], 2'd2))
            hyst[i] <= wdata_i[11:0];      // R1
        end
      end
      // status clear, all-ones equals clearing every bit
      if (clr_all)
        status <= 8'h00;                   // R16
      else if (wr_i && ptr_i == `ALM_PTR_STATUS)
        status <= status & ~wdata_i[7:0];  // R17 R18 R19
      if (clr_all)
        in_alert <= 4'h0;                  // R8 R13
      // once per conversion, on its own channel
      if (conv_done_i) begin               // R24
        // flag covers this result's own violation as well as others
        last_result <= {any_alert | (!capture && (over || under)),
                        1'b0, conv_chan_i, conv_result_i}; // R3 R5
        if (capture) begin
          if (conv_result_i > c_up)
            upper[conv_chan_i] <= conv_result_i; // R12
          if (conv_result_i < c_lo)
            lower[conv_chan_i] <= conv_result_i; // R12
        end else if (over || under) begin
          in_alert[conv_chan_i] <= 1'b1;   // R3 R5
          // set wins over any clear in this cycle
          status <= (clr_all ? 8'h00 :
                     (wr_i && ptr_i == `ALM_PTR_STATUS) ?
                     status & ~wdata_i[7:0] : status)
                    | ({6'h00, over, under} << {conv_chan_i, 1'b0}); // R14 R15
        end else if (recov && !clr_all)
          in_alert[conv_chan_i] <= 1'b0;   // R4 R6 R13
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs: flag, pin, read data
  // ----------------------------------------------------------------
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      alert_flag_o <= 1'b0;
      alert_o      <= 1'b1;                // idle, active low default
      rdata_o      <= 16'h0000;
    end else begin
      alert_flag_o <= any_alert;           // R20
      // R23: polarity bit picks the active level
      alert_o <= (pin_mode && any_alert) ? cfg[`ALM_CFG_POL]
                                         : ~cfg[`ALM_CFG_POL]; // R20 R21
      rdata_o <= 16'h0000;
      case (ptr_i)
        `ALM_PTR_RESULT: rdata_o <= last_result;
        `ALM_PTR_STATUS: rdata_o <= {8'h00, status};
        `ALM_PTR_CONFIG: rdata_o <= {8'h00, cfg};
        `ALM_PTR_CYCLE:  rdata_o <= {8'h00, cycle};
        default: begin
          for (i = 0; i < 4; i = i + 1) begin
            if (ptr_i == lim_ptr(i[1:0], 2'd0))
              rdata_o <= {any_alert, 3'b000, lower[i]}; // R9
            if (ptr_i == lim_ptr(i[1:0], 2'd1))
              rdata_o <= {any_alert, 3'b000, upper[i]}; // R9 R13
            if (ptr_i == lim_ptr(i[1:0], 2'd2))
              rdata_o <= {any_alert, 3'b000, hyst[i]}; // R9
          end
        end
      endcase
    end
  end

endmodule // alm_monitor

// file: testbench/alm_monitor_checker.sv
`timescale 1ns/10ps
// ----------------------------------------
// limit monitor port checker
// ----------------------------------------
module alm_monitor_checker (
  input wire        clock_i,      // clock
  input wire        reset_n_i,    // reset, low
  input wire        wr_i,         // write strobe
  input wire [3:0]  ptr_i,        // pointer
  input wire [15:0] wdata_i,      // write data
  input wire [15:0] rdata_o,      // read data
  input wire        conv_done_i,  // result in
  input wire        alert_o,      // pin
  input wire        alert_flag_o, // flag
  input wire [7:0]  config_o      // config
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // quiet cycle then status read; no conversion may re-set bits
  sequence s_then_stat;
    !wr_i && !conv_done_i ##1 ptr_i == 4'h1 && !wr_i && !conv_done_i;
  endsequence
  sequence s_cfg_clr;
    wr_i && ptr_i == 4'h2 && wdata_i[2:1] == 2'b11 && !conv_done_i;
  endsequence
  a_status_w1c: assert property (
    wr_i && ptr_i == 4'h1 && !conv_done_i ##1 s_then_stat
    |=> (rdata_o[7:0] & $past(wdata_i[7:0], 3)) == 8'h00)
    else $error("written status bit still set");
  a_cfg_clears_status: assert property (
    s_cfg_clr ##1 s_then_stat |=> rdata_o[7:0] == 8'h00)
    else $error("status kept after config clear");
  a_cfg_d1_reads: assert property (
    s_cfg_clr |=> config_o[2:1] == 2'b10)
    else $error("config clear readback wrong");
  a_cfg_alert_clear: assert property (
    s_cfg_clr |=> ##[0:1] (!alert_flag_o && alert_o != config_o[0]))
    else $error("alert kept after config clear");
  a_pin_quiet_off: assert property (
    ($stable(config_o) && config_o[2:1] == 2'b00) [*2]
    |-> alert_o != config_o[0])
    else $error("pin active while disabled");
  a_pin_follows_flag: assert property (
    ($stable(config_o) && config_o[2:1] == 2'b10) [*2]
    |-> alert_o == (alert_flag_o ~^ config_o[0]))
    else $error("pin level disagrees with flag");
  a_flag_needs_conv: assert property (
    $rose(alert_flag_o) |-> $past(conv_done_i, 2))
    else $error("flag rose without conversion");
  a_limit_pad_zero: assert property (
    $past(ptr_i) >= 4'h4 |-> rdata_o[14:12] == 3'h0)
    else $error("limit read pad bits set");
endmodule // alm_monitor_checker
bind alm_monitor alm_monitor_checker u_alm_monitor_checker (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .wr_i(wr_i), .ptr_i(ptr_i),
  .wdata_i(wdata_i), .rdata_o(rdata_o), .conv_done_i(conv_done_i),
  .alert_o(alert_o), .alert_flag_o(alert_flag_o), .config_o(config_o));

// file: testbench/alm_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// host register access model
// ----------------------------------------
module alm_host_model (
  input  wire        clock_i, // device clock
  input  wire [15:0] rdata_i, // read data
  output reg         wr_o,    // write strobe
  output reg  [3:0]  ptr_o,   // pointer
  output reg  [15:0] wdata_o  // write data
);
  initial {wr_o, ptr_o, wdata_o} = 21'h000000;
  // one-cycle strobe; data scrambled once released
  task wr(input [3:0] p, input [15:0] d);
    begin
      @(posedge clock_i);
      {wr_o, ptr_o, wdata_o} <= {1'b1, p, d};
      @(posedge clock_i);
      wr_o <= 1'b0;
      wdata_o <= ~d;
    end
  endtask
  // read data lags the pointer by one edge
  task rd(input [3:0] p, output [15:0] d);
    begin
      @(posedge clock_i);
      ptr_o <= p;
      repeat (2) @(posedge clock_i);
      #1 d = rdata_i;
    end
  endtask
endmodule // alm_host_model

// file: testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  reg         clock_i = 1'b0;
  reg         reset_n_i = 1'b0;
  reg         conv_done_i = 1'b0;
  reg  [1:0]  conv_chan_i = 2'h0;
  reg  [11:0] conv_result_i = 12'h000;
  wire        wr_i, alert_o, alert_flag_o;
  wire [3:0]  ptr_i;
  wire [15:0] wdata_i, rdata_o;
  wire [7:0]  config_o;
  integer     err_count = 0;
  integer     tests_run = 0;
  integer     c;
  reg  [15:0] d;
  always #2 clock_i = ~clock_i;
  alm_monitor #(.TEN_BIT(0)) u_alm_monitor (.clock_i(clock_i),
    .reset_n_i(reset_n_i), .wr_i(wr_i), .ptr_i(ptr_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .conv_done_i(conv_done_i), .conv_chan_i(conv_chan_i),
    .conv_result_i(conv_result_i), .alert_o(alert_o),
    .alert_flag_o(alert_flag_o), .config_o(config_o));
  alm_host_model u_alm_host_model (.clock_i(clock_i), .rdata_i(rdata_o),
    .wr_o(wr_i), .ptr_o(ptr_i), .wdata_o(wdata_i));
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("FAIL %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // one result, then wait out the two-edge flag latency
  task conv(input [1:0] ch, input [11:0] r, input fl, input al);
    begin
      @(posedge clock_i);
      {conv_done_i, conv_chan_i, conv_result_i} <= {1'b1, ch, r};
      @(posedge clock_i);
      conv_done_i <= 1'b0;
      conv_result_i <= ~r;
      repeat (2) @(posedge clock_i);
      #1 chk("flag", {15'h0, fl}, {15'h0, alert_flag_o});
      chk("pin", {15'h0, al}, {15'h0, alert_o});
    end
  endtask
  task rdchk(input [3:0] p, input [15:0] e);
    begin
      u_alm_host_model.rd(p, d);
      chk("reg", e, d);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // limits and hysteresis at power-up, every channel
  task t_reset;
    for (c = 0; c < 4; c = c + 1) begin
      rdchk(4'h4 + 3 * c, 16'h0000);
      rdchk(4'h5 + 3 * c, 16'h0FFF);
      rdchk(4'h6 + 3 * c, 16'h0008);
    end
  endtask
  // upper limit on channel 1, pin active low, default hysteresis
  task t_high;
    begin
      u_alm_host_model.wr(4'h2, 16'h0004);
      u_alm_host_model.wr(4'h8, 16'h0100);
      conv(2'h1, 12'h101, 1'b1, 1'b0);
      rdchk(4'h1, 16'h0008);
      conv(2'h1, 12'h0F9, 1'b1, 1'b0);
      conv(2'h1, 12'h0F8, 1'b0, 1'b1);
    end
  endtask
  // lower limit on channel 0 with own hysteresis, pin active high
  task t_low;
    begin
      u_alm_host_model.wr(4'h2, 16'h0005);
      u_alm_host_model.wr(4'h6, 16'h0010);
      u_alm_host_model.wr(4'h4, 16'h0200);
      conv(2'h0, 12'h1FF, 1'b1, 1'b1);
      rdchk(4'h1, 16'h0009);
      rdchk(4'h4, 16'h8200);
      conv(2'h0, 12'h20F, 1'b1, 1'b1);
      conv(2'h0, 12'h210, 1'b0, 1'b0);
      rdchk(4'h1, 16'h0009);
    end
  endtask
  // single-bit, all-ones and config clears
  task t_clear;
    begin
      u_alm_host_model.wr(4'h1, 16'h0001);
      rdchk(4'h1, 16'h0008);
      u_alm_host_model.wr(4'h1, 16'h00FF);
      rdchk(4'h1, 16'h0000);
      conv(2'h1, 12'h101, 1'b1, 1'b1);
      u_alm_host_model.wr(4'h2, 16'h0006);
      rdchk(4'h1, 16'h0000);
      chk("cfg", 16'h0004, {8'h00, config_o});
      chk("pin", 16'h0001, {15'h0, alert_o});
      chk("flag", 16'h0000, {15'h0, alert_flag_o});
    end
  endtask
  // all-ones hysteresis turns channel 2 limits into min and max
  task t_minmax;
    begin
      u_alm_host_model.wr(4'hC, 16'h0FFF);
      u_alm_host_model.wr(4'hA, 16'h0FFF);
      u_alm_host_model.wr(4'hB, 16'h0000);
      conv(2'h2, 12'h123, 1'b0, 1'b1);
      conv(2'h2, 12'h456, 1'b0, 1'b1);
      rdchk(4'hB, 16'h0456);
      rdchk(4'hA, 16'h0123);
    end
  endtask
  // pin disabled: flag only, result register carries the flag
  task t_quiet;
    begin
      u_alm_host_model.wr(4'h2, 16'h0000);
      conv(2'h0, 12'h100, 1'b1, 1'b1);
      rdchk(4'h0, 16'h8100);
      u_alm_host_model.wr(4'h2, 16'h0006);
      rdchk(4'h1, 16'h0000);
      chk("flag", 16'h0000, {15'h0, alert_flag_o});
    end
  endtask
  initial begin
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_reset;
    t_high;
    t_low;
    t_clear;
    t_minmax;
    t_quiet;
    give_verdict;
  end
  // whole run is well under a thousand cycles
  initial begin
    #20000;
    err_count = err_count + 1;
    give_verdict;
  end
endmodule // tb_top
